// File: hdl/exdbg_map.vh
// exdbg_map.vh: constants for the exception and debug entry sequencer
// assumes inclusion by hdl/exdbg_top.v and the testbench; definitions only
`ifndef EXDBG_MAP_VH
`define EXDBG_MAP_VH

// wishbone register byte addresses
`define EXDBG_ADR_CTRL      8'h00
`define EXDBG_ADR_SR        8'h04
`define EXDBG_ADR_VBR       8'h08
`define EXDBG_ADR_PC        8'h0c
`define EXDBG_ADR_SP        8'h10
`define EXDBG_ADR_EVENT     8'h14
`define EXDBG_ADR_STATUS    8'h18
`define EXDBG_ADR_FRAME0    8'h1c
`define EXDBG_ADR_FRAME1    8'h20
`define EXDBG_ADR_VADDR     8'h24
`define EXDBG_ADR_IACKVEC   8'h28
`define EXDBG_ADR_OPCODE    8'h2c

// status word fields
`define EXDBG_SR_TRACE_HI   15
`define EXDBG_SR_TRACE_LO   14
`define EXDBG_SR_SUPER      13
`define EXDBG_SR_IPM_LSB    8

// event register bit positions (software writes one to raise)
`define EXDBG_EV_ILLEGAL    0
`define EXDBG_EV_ODD_FETCH  1
`define EXDBG_EV_ODD_OPND   2
`define EXDBG_EV_PRIV       3
`define EXDBG_EV_INSN_DONE  4
`define EXDBG_EV_FLOW       5
`define EXDBG_EV_BUS_FAULT  6
`define EXDBG_EV_INTR       7

// vector numbers
`define EXDBG_VEC_BUS_ERR   8'h02
`define EXDBG_VEC_ADDR_ERR  8'h03
`define EXDBG_VEC_ILLEGAL   8'h04
`define EXDBG_VEC_PRIV      8'h08
`define EXDBG_VEC_TRACE     8'h09
`define EXDBG_VEC_LINE_A    8'h0a
`define EXDBG_VEC_LINE_F    8'h0b
`define EXDBG_VEC_BREAKPOINT_REQUEST_N      8'h0c

// opcodes
`define EXDBG_OP_SWBKPT_LO  16'h4848
`define EXDBG_OP_SWBKPT_HI  16'h484f
`define EXDBG_OP_BG_ENTRY   16'h4afa

// cpu space used by interrupt acknowledge
`define EXDBG_IACK_SPACE    4'hf

// reset values
`define EXDBG_SR_RESET      16'h2700
`define EXDBG_VBR_RESET     32'h00000000

`endif

// File: hdl/exdbg_top.v
// exdbg_top.v: exception sequencer with background-debug entry control
// assumes a classic wishbone master on clk_i and an asynchronous active-low
// breakpoint request pin from external hardware and on-chip peripherals
//
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/100ps
`include "exdbg_map.vh"

module exdbg_top
(
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	input  wire        wb_we_i,
	input  wire [3:0]  wb_sel_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	output reg         wb_ack_o,
	input  wire        breakpoint_request_n_i,
	input  wire        strobe_end_i,
	input  wire        iack_done_i,
	input  wire [7:0]  iack_vector_i,
	input  wire [2:0]  intr_level_i,
	output reg         iack_req_o,
	output reg  [3:0]  iack_space_o,
	output reg         debug_halt_o,
	output reg         cpu_halted_o,
	output reg         background_debug_mode_o
);

	localparam ST_IDLE  = 3'd0;
	localparam ST_ENTRY = 3'd1;
	localparam ST_VEC   = 3'd2;
	localparam ST_IACK  = 3'd3;
	localparam ST_FRAME = 3'd4;
	localparam ST_LOAD  = 3'd5;

	reg        breakpoint_request_n_s1_q;
	reg        breakpoint_request_n_s2_q;
	reg        breakpoint_request_n_smp_q;
	reg        rst_prev_q;
	reg [2:0]  st_q;
	reg [15:0] sr_q;
	reg [15:0] sr_copy_q;
	reg [31:0] vbr_q;
	reg [31:0] pc_q;
	reg [31:0] sp_q;
	reg [31:0] frame0_q;
	reg [31:0] frame1_q;
	reg [31:0] vaddr_q;
	reg [31:0] iackvec_q;
	reg [15:0] opcode_q;
	reg        op_valid_q;
	reg [7:0]  ev_q;
	reg [7:0]  vec_q;
	reg        is_intr_q;
	reg        fault_pend_q;
	reg        pending_q;
	reg        trace_flow_q;

	// decoded opcode classes, used by the opcode path and status readback
	function [2:0] op_class;
		input [15:0] op;
		begin
			if (op == `EXDBG_OP_BG_ENTRY)
				op_class = 3'd1;
			else if (op >= `EXDBG_OP_SWBKPT_LO && op <= `EXDBG_OP_SWBKPT_HI)
				op_class = 3'd2;
			else if (op[15:12] == 4'ha)
				op_class = 3'd3;
			else if (op[15:12] == 4'hf)
				op_class = 3'd4;
			else
				op_class = 3'd0;
		end
	endfunction

	wire       wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire       wb_wr     = wb_req & wb_we_i;
	wire [2:0] cls       = op_class(opcode_q);
	wire       idle      = (st_q == ST_IDLE) & ~debug_halt_o & ~cpu_halted_o;
	wire       breakpoint_request_n_seen = breakpoint_request_n_smp_q;
	wire       mask_ok   = (intr_level_i > sr_q[10:8]) | (intr_level_i == 3'd7);
	// events raised by this cycle's write; a raise wins over a clear in the same cycle
	wire [7:0] ev_set    = (wb_wr & wb_sel_i[0] & (wb_adr_i == `EXDBG_ADR_EVENT)) ? wb_dat_i[7:0] : 8'h00;

	// pin synchroniser for the breakpoint request
	always @(posedge clk_i)
	begin
		breakpoint_request_n_s1_q <= breakpoint_request_n_i;
		breakpoint_request_n_s2_q <= breakpoint_request_n_s1_q;
		rst_prev_q <= rst_i;
	end

	// debug enable latched at reset release, held through the next reset until its release
	always @(posedge clk_i)
	begin
		if (rst_prev_q & ~rst_i)
			background_debug_mode_o <= ~breakpoint_request_n_s2_q;
		else if (rst_i)
			background_debug_mode_o <= background_debug_mode_o;
	end

	// breakpoint request taken at the data strobe end, like read data
	always @(posedge clk_i)
	begin
		if (rst_i)
			breakpoint_request_n_smp_q <= 1'b0;
		else if (strobe_end_i & ~breakpoint_request_n_s2_q & ~rst_prev_q)
			breakpoint_request_n_smp_q <= 1'b1;
		else if (idle)
			breakpoint_request_n_smp_q <= 1'b0;
	end

	// wishbone slave, one wait state, ack drops after one cycle
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= wb_req;
			case (wb_adr_i)
				`EXDBG_ADR_CTRL:    wb_dat_o <= {31'h00000000, trace_flow_q};
				`EXDBG_ADR_SR:      wb_dat_o <= {16'h0000, sr_q};
				`EXDBG_ADR_VBR:     wb_dat_o <= vbr_q;
				`EXDBG_ADR_PC:      wb_dat_o <= pc_q;
				`EXDBG_ADR_SP:      wb_dat_o <= sp_q;
				`EXDBG_ADR_EVENT:   wb_dat_o <= {24'h000000, ev_q};
				`EXDBG_ADR_STATUS:  wb_dat_o <= {16'h0000, vec_q, cls, st_q, cpu_halted_o, debug_halt_o};
				`EXDBG_ADR_FRAME0:  wb_dat_o <= frame0_q;
				`EXDBG_ADR_FRAME1:  wb_dat_o <= frame1_q;
				`EXDBG_ADR_VADDR:   wb_dat_o <= vaddr_q;
				`EXDBG_ADR_IACKVEC: wb_dat_o <= iackvec_q;
				`EXDBG_ADR_OPCODE:  wb_dat_o <= {15'h0000, op_valid_q, opcode_q};
				default:            wb_dat_o <= 32'h00000000;
			endcase
		end
	end

	// exception sequencer and software-visible state
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_q         <= ST_IDLE;
			sr_q         <= `EXDBG_SR_RESET;
			sr_copy_q    <= `EXDBG_SR_RESET;
			vbr_q        <= `EXDBG_VBR_RESET;
			pc_q         <= 32'h00000000;
			sp_q         <= 32'h00000000;
			frame0_q     <= 32'h00000000;
			frame1_q     <= 32'h00000000;
			vaddr_q      <= 32'h00000000;
			iackvec_q    <= 32'h00000000;
			opcode_q     <= 16'h0000;
			op_valid_q   <= 1'b0;
			ev_q         <= 8'h00;
			vec_q        <= 8'h00;
			is_intr_q    <= 1'b0;
			fault_pend_q <= 1'b0;
			pending_q    <= 1'b0;
			trace_flow_q <= 1'b0;
			iack_req_o   <= 1'b0;
			iack_space_o <= 4'h0;
			debug_halt_o <= 1'b0;
			cpu_halted_o <= 1'b0;
		end
		else
		begin
			// register writes; events raised by software writing ones
			if (wb_wr & wb_sel_i[0])
			begin
				case (wb_adr_i)
					`EXDBG_ADR_CTRL:   trace_flow_q <= wb_dat_i[0];
					`EXDBG_ADR_SR:     sr_q <= wb_dat_i[15:0];
					`EXDBG_ADR_VBR:    vbr_q <= wb_dat_i;
					`EXDBG_ADR_PC:     pc_q <= wb_dat_i;
					`EXDBG_ADR_SP:     sp_q <= wb_dat_i;
					`EXDBG_ADR_IACKVEC: iackvec_q <= wb_dat_i;
					`EXDBG_ADR_EVENT:  ev_q <= ev_q | wb_dat_i[7:0];
					`EXDBG_ADR_OPCODE:
					begin
						opcode_q   <= wb_dat_i[15:0];
						op_valid_q <= 1'b1;
					end
					default: ;
				endcase
			end
			case (st_q)
				ST_IDLE:
				if (~debug_halt_o & ~cpu_halted_o)
				begin
					if (ev_q[`EXDBG_EV_BUS_FAULT])
					begin
						ev_q[`EXDBG_EV_BUS_FAULT] <= ev_set[`EXDBG_EV_BUS_FAULT];
						if (fault_pend_q)
						begin
							fault_pend_q <= 1'b0;
							if (background_debug_mode_o)
								debug_halt_o <= 1'b1;
							else
								cpu_halted_o <= 1'b1;
						end
						else
						begin
							fault_pend_q <= 1'b1;
							vec_q <= `EXDBG_VEC_BUS_ERR;
							st_q  <= ST_ENTRY;
						end
					end
					else if (breakpoint_request_n_seen)
					begin
						if (background_debug_mode_o)
							debug_halt_o <= 1'b1;
						else
						begin
							vec_q <= `EXDBG_VEC_BREAKPOINT_REQUEST_N;
							st_q  <= ST_ENTRY;
						end
					end
					else if (op_valid_q)
					begin
						op_valid_q <= 1'b0;
						if (cls == 3'd1 && background_debug_mode_o)
							debug_halt_o <= 1'b1;
						else if (cls == 3'd3 || cls == 3'd4)
						begin
							vec_q <= (cls == 3'd3) ? `EXDBG_VEC_LINE_A : `EXDBG_VEC_LINE_F;
							st_q  <= ST_ENTRY;
						end
						else if (cls != 3'd0)
						begin
							vec_q <= `EXDBG_VEC_ILLEGAL;
							st_q  <= ST_ENTRY;
						end
					end
					else if (ev_q[3:0] != 4'h0)
					begin
						if (ev_q[`EXDBG_EV_ILLEGAL])
							vec_q <= `EXDBG_VEC_ILLEGAL;
						else if (ev_q[`EXDBG_EV_PRIV])
							vec_q <= `EXDBG_VEC_PRIV;
						else
							vec_q <= `EXDBG_VEC_ADDR_ERR;
						ev_q[3:0] <= ev_set[3:0];
						st_q <= ST_ENTRY;
					end
					else if (ev_q[`EXDBG_EV_INSN_DONE])
					begin
						ev_q[`EXDBG_EV_INSN_DONE] <= ev_set[`EXDBG_EV_INSN_DONE];
						ev_q[`EXDBG_EV_FLOW] <= ev_set[`EXDBG_EV_FLOW];
						fault_pend_q <= 1'b0;
						if (sr_q[`EXDBG_SR_TRACE_HI] | (sr_q[`EXDBG_SR_TRACE_LO] & ev_q[`EXDBG_EV_FLOW] & trace_flow_q))
						begin
							vec_q <= `EXDBG_VEC_TRACE;
							st_q  <= ST_ENTRY;
						end
					end
					else if (ev_q[`EXDBG_EV_INTR] & mask_ok)
					begin
						ev_q[`EXDBG_EV_INTR] <= ev_set[`EXDBG_EV_INTR];
						is_intr_q <= 1'b1;
						st_q      <= ST_ENTRY;
					end
				end
				ST_ENTRY:
				begin
					sr_copy_q <= sr_q;
					sr_q[`EXDBG_SR_SUPER]    <= 1'b1;
					sr_q[`EXDBG_SR_TRACE_HI] <= 1'b0;
					sr_q[`EXDBG_SR_TRACE_LO] <= 1'b0;
					if (is_intr_q)
						sr_q[10:8] <= intr_level_i;
					st_q <= is_intr_q ? ST_IACK : ST_VEC;
					iack_req_o   <= is_intr_q;
					iack_space_o <= is_intr_q ? `EXDBG_IACK_SPACE : 4'h0;
				end
				ST_IACK:
				if (iack_done_i)
				begin
					vec_q        <= iack_vector_i;
					iack_req_o   <= 1'b0;
					iack_space_o <= 4'h0;
					is_intr_q    <= 1'b0;
					st_q         <= ST_VEC;
				end
				ST_VEC:
				begin
					vaddr_q <= vbr_q + {22'h000000, vec_q, 2'b00};
					st_q    <= ST_FRAME;
				end
				ST_FRAME:
				begin
					sp_q     <= sp_q - 32'h00000008;
					frame0_q <= {sr_copy_q, pc_q[31:16]};
					frame1_q <= {pc_q[15:0], 4'h0, 2'b00, vec_q, 2'b00};
					st_q     <= ST_LOAD;
				end
				ST_LOAD:
				begin
					// software supplies the fetched vector through IACKVEC
					pc_q <= iackvec_q;
					pending_q <= |ev_q;
					st_q <= ST_IDLE;
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

endmodule // exdbg_top

// File: verif/exdbg_asserts.sv
// checker: port relations of the exception and debug entry block
// assumes bind onto exdbg_top, one clock, sync reset
`timescale 1ns/100ps
module exdbg_asserts
(
	input wire		clk_i,
	input wire		rst_i,
	input wire		wb_cyc_i,
	input wire		wb_stb_i,
	input wire		wb_ack_o,
	input wire		breakpoint_request_n_i,
	input wire		iack_req_o,
	input wire [3:0]	iack_space_o,
	input wire		debug_halt_o,
	input wire		cpu_halted_o,
	input wire		background_debug_mode_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// bus, acknowledge cycle and debug entry relations
	ack_once_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not one cycle");
	iack_space_a: assert property (iack_req_o |-> iack_space_o == 4'hf)
		else $error("iack space wrong");
	space_idle_a: assert property (!iack_req_o |-> iack_space_o == 4'h0)
		else $error("space set while idle");
	enable_latch_a: assert property ($fell(rst_i) |-> ##2 background_debug_mode_o == !$past(breakpoint_request_n_i, 4))
		else $error("enable not latched");
	enable_hold_a: assert property (!$past(rst_i, 3) |-> $stable(background_debug_mode_o))
		else $error("enable changed");
	halt_sticky_a: assert property (debug_halt_o |=> debug_halt_o)
		else $error("debug halt dropped");
	halt_enabled_a: assert property (debug_halt_o |-> background_debug_mode_o && !cpu_halted_o)
		else $error("debug entry while disabled");
	fault_stop_a: assert property (cpu_halted_o |-> !background_debug_mode_o && !debug_halt_o)
		else $error("halt while enabled");
endmodule // exdbg_asserts

bind exdbg_top exdbg_asserts i_exdbg_asserts (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
	.breakpoint_request_n_i, .iack_req_o, .iack_space_o, .debug_halt_o, .cpu_halted_o,
	.background_debug_mode_o);

// File: verif/exdbg_partner.sv
// partner: breakpoint requester, data strobe timing, interrupt source
// assumes bench commands on the same clock
`timescale 1ns/100ps
module exdbg_partner
#(parameter VECTOR = 8'h40)
(
	input wire		clk_i,
	input wire		level_n_i,	// level held around reset
	input wire		bp_go_i,	// start one breakpoint
	input wire		slow_i,		// slow interrupt answer
	input wire		iack_req_i,
	output wire		breakpoint_request_n_n_o,
	output wire		strobe_end_o,
	output wire		iack_done_o,
	output wire [7:0]	iack_vector_o
);
	reg [3:0]	cnt_q = 4'h0;
	reg [3:0]	age_q = 4'h0;
	reg [3:0]	wait_q = 4'h0;
	reg		bp_q = 1'b0;
	// strobe ends every fourth clock; request outlasts the synchroniser
	always @(posedge clk_i)
	begin
		cnt_q <= cnt_q + 4'h1;
		age_q <= bp_q ? age_q + 4'h1 : 4'h0;
		wait_q <= iack_req_i ? wait_q + 4'h1 : 4'h0;
		if (bp_go_i)
			bp_q <= 1'b1;
		else if (strobe_end_o && age_q > 4'h2)
			bp_q <= 1'b0;
	end
	// one shared line for analyzer and peripherals
	assign breakpoint_request_n_n_o = level_n_i & ~bp_q;
	assign strobe_end_o = cnt_q[1:0] == 2'h3;
	// vector valid only with the done pulse
	assign iack_done_o = iack_req_i && wait_q == (slow_i ? 4'h7 : 4'h1);
	assign iack_vector_o = iack_done_o ? VECTOR : {cnt_q, ~cnt_q};
endmodule // exdbg_partner

// File: verif/tb.sv
// testbench: wishbone sequences against exdbg_top and the partner
// assumes exdbg_map.vh on the include path
`timescale 1ns/100ps
`include "exdbg_map.vh"
module tb;
	localparam [31:0]	VECTOR_TABLE_BASE = 32'h1000;
	localparam [7:0]	IVEC = 8'h40;
	// address, data, vector (00: none expected)
	localparam [415:0]	TAB = {32'h04_8000_00, 32'h14_0010_09, 32'h14_0001_04, 32'h00_0001_00,
		32'h04_4000_00, 32'h14_0030_09, 32'h14_0002_03, 32'h14_0004_03, 32'h14_0008_08,
		32'h2c_4848_04, 32'h2c_484f_04, 32'h2c_a000_0a, 32'h2c_f000_0b};
	reg		clk = 1'b0;
	reg		rst = 1'b1;
	reg		stb = 1'b0;
	reg		we = 1'b0;
	reg		lvl_n = 1'b1;
	reg		bp_go = 1'b0;
	reg		slow = 1'b0;
	reg [2:0]	lvl = 3'h0;
	reg [7:0]	adr = 8'h00;
	reg [31:0]	wdat = 32'h0;
	reg [31:0]	got;
	reg [31:0]	ent;
	wire [31:0]	rdat;
	wire [7:0]	ivec;
	wire		ack, bk_n, se, idone, ireq, dhalt, chalt, background_debug_mode;
	wire [1:0]	halts = {chalt, dhalt};
	integer		miscompares = 0;
	integer		checks = 0;
	integer		i;

	exdbg_top i_exdbg_top (.clk_i(clk), .rst_i(rst), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(stb), .wb_stb_i(stb), .wb_ack_o(ack),
		.breakpoint_request_n_i(bk_n), .strobe_end_i(se), .iack_done_i(idone), .iack_vector_i(ivec),
		.intr_level_i(lvl), .iack_req_o(ireq), .iack_space_o(), .debug_halt_o(dhalt),
		.cpu_halted_o(chalt), .background_debug_mode_o(background_debug_mode));
	exdbg_partner #(.VECTOR(IVEC)) i_exdbg_partner (.clk_i(clk), .level_n_i(lvl_n), .bp_go_i(bp_go),
		.slow_i(slow), .iack_req_i(ireq), .breakpoint_request_n_n_o(bk_n), .strobe_end_o(se), .iack_done_o(idone),
		.iack_vector_o(ivec));

	// 25 ns clock
	always #12.5 clk = ~clk;

	task chk(input string nm, input [31:0] e, input [31:0] g);
	begin
		checks = checks + 1;
		if (g !== e)
		begin
			miscompares = miscompares + 1;
			$display("Error %0s expected %h seen %h", nm, e, g);
		end
	end
	endtask

	// classic single cycle, bounded wait for ack
	task wb(input [7:0] a, input w, input [31:0] d);
		integer n;
	begin
		@(posedge clk);
		adr <= a;
		we <= w;
		wdat <= d;
		stb <= 1'b1;
		n = 0;
		@(posedge clk);
		while (ack !== 1'b1 && n < 50)
		begin
			@(posedge clk);
			n = n + 1;
		end
		got = rdat;
		stb <= 1'b0;
		we <= 1'b0;
		if (n == 50)
			chk("ack", 1, 0);
	end
	endtask

	task rd(input string nm, input [7:0] a, input [31:0] m, input [31:0] e);
	begin
		wb(a, 1'b0, 32'h0);
		chk(nm, e, got & m);
	end
	endtask

	// wait till idle, then vector and vector address
	task exc(input [7:0] v);
		integer n;
	begin
		n = 0;
		got = 32'h1c;
		while (got[4:2] !== 3'h0 && n < 40)
		begin
			wb(`EXDBG_ADR_STATUS, 1'b0, 32'h0);
			n = n + 1;
		end
		rd("vector", `EXDBG_ADR_STATUS, 32'hff00, {16'h0, v, 8'h0});
		rd("vaddr", `EXDBG_ADR_VADDR, 32'hffffffff, VECTOR_TABLE_BASE + {22'h0, v, 2'h0});
	end
	endtask

	task hold(input k, input string nm);
		integer n;
	begin
		n = 0;
		while (halts[k] !== 1'b1 && n < 40)
		begin
			@(posedge clk);
			n = n + 1;
		end
		chk(nm, 1, halts[k]);
	end
	endtask

	// reset with the request line at n for two clocks, released before reset ends
	task rst_dev(input n);
	begin
		@(posedge clk);
		rst <= 1'b1;
		lvl_n <= n;
		repeat (2) @(posedge clk);
		lvl_n <= 1'b1;
		@(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		chk("enable", !n, background_debug_mode);
		wb(`EXDBG_ADR_VBR, 1'b1, VECTOR_TABLE_BASE);
	end
	endtask

	task summarize;
	begin
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask

	// watchdog
	initial
	begin
		#300000;
		miscompares = miscompares + 1;
		summarize;
	end

	// disabled then enabled debug sequences
	initial
	begin
		rst_dev(1'b1);
		rd("sr", `EXDBG_ADR_SR, 32'hffff, `EXDBG_SR_RESET);
		rd("hole", 8'h3c, 32'hffffffff, 32'h0);
		wb(`EXDBG_ADR_SR, 1'b1, 32'hc000);
		wb(`EXDBG_ADR_OPCODE, 1'b1, {16'h0, `EXDBG_OP_BG_ENTRY});
		exc(`EXDBG_VEC_ILLEGAL);
		rd("frame", `EXDBG_ADR_FRAME0, 32'hffff0000, 32'hc0000000);
		rd("sr", `EXDBG_ADR_SR, 32'he000, 32'h2000);
		for (i = 0; i < 13; i = i + 1)
		begin
			ent = TAB[415 - 32 * i -: 32];
			wb(ent[31:24], 1'b1, {16'h0, ent[23:8]});
			if (ent[7:0] != 8'h00)
				exc(ent[7:0]);
		end
		wb(`EXDBG_ADR_SR, 1'b1, 32'h2000);
		lvl <= 3'h5;
		slow <= 1'b1;
		wb(`EXDBG_ADR_EVENT, 1'b1, 32'h80);
		exc(IVEC);
		rd("mask", `EXDBG_ADR_SR, 32'h0700, 32'h0500);
		lvl <= 3'h0;
		bp_go <= 1'b1;
		@(posedge clk);
		bp_go <= 1'b0;
		// let the synchroniser and the strobe phase bring the request in
		repeat (16) @(posedge clk);
		exc(`EXDBG_VEC_BREAKPOINT_REQUEST_N);
		chk("dhalt", 0, dhalt);
		wb(`EXDBG_ADR_EVENT, 1'b1, 32'h40);
		wb(`EXDBG_ADR_EVENT, 1'b1, 32'h40);
		hold(1'b1, "stop");
		rst_dev(1'b0);
		wb(`EXDBG_ADR_OPCODE, 1'b1, {16'h0, `EXDBG_OP_SWBKPT_LO});
		exc(`EXDBG_VEC_ILLEGAL);
		chk("dhalt", 0, dhalt);
		wb(`EXDBG_ADR_OPCODE, 1'b1, {16'h0, `EXDBG_OP_BG_ENTRY});
		hold(1'b0, "background_entry_opcode");
		rst_dev(1'b0);
		bp_go <= 1'b1;
		@(posedge clk);
		bp_go <= 1'b0;
		hold(1'b0, "breakpoint_request_n");
		chk("iack", 0, ireq);
		rst_dev(1'b0);
		wb(`EXDBG_ADR_EVENT, 1'b1, 32'h40);
		wb(`EXDBG_ADR_EVENT, 1'b1, 32'h40);
		hold(1'b0, "fault");
		chk("stop", 0, chalt);
		rst_dev(1'b1);
		summarize;
	end
endmodule // tb
